// >>> logic/dbsp_pair_array.sv
// Storage of the port: two equal arrays, one word of each burst in each
`timescale 1ns/1ps
module dbsp_pair_array #(
   parameter int DW = dbsp_pkg::DATA_W,
   parameter int AW = dbsp_pkg::ADDR_W,
   parameter int LW = dbsp_pkg::LANE_W,
   parameter int NL = dbsp_pkg::LANES
) (
   input  wire logic          clk,
   input  wire logic          en,
   input  wire logic          wrEn,
   input  wire logic [AW-2:0] wrIdx,
   input  wire logic          wrStart,
   input  wire logic [DW-1:0] wrWord0,
   input  wire logic [DW-1:0] wrWord1,
   input  wire logic [NL-1:0] wrSel0N,
   input  wire logic [NL-1:0] wrSel1N,
   input  wire logic [AW-2:0] rdIdx,
   input  wire logic          rdStart,
   output logic      [DW-1:0] rdWord0,
   output logic      [DW-1:0] rdWord1
);
   localparam int DEPTH = 1 << (AW - 1);

   wire [dbsp_pkg::ARRAYS-1:0][DW-1:0] rdArr;

   // The burst bit picks the array, so a burst never needs two accesses
   // to the same array and both words commit on one edge
   for (genvar a = 0; a < dbsp_pkg::ARRAYS; a++) begin : g_arr
      for (genvar l = 0; l < NL; l++) begin : g_lane
         logic [LW-1:0] store [DEPTH];
         logic          first;
         logic [LW-1:0] laneData;
         logic          laneSelN;

         assign first = (wrStart == 1'(a));
         assign laneData = first ? wrWord0[l*LW +: LW] : wrWord1[l*LW +: LW];
         assign laneSelN = first ? wrSel0N[l] : wrSel1N[l];

         always_ff @(posedge clk) begin
            if (en && wrEn && !laneSelN) begin // R7 R8
               store[wrIdx] <= laneData;
            end
         end

         assign rdArr[a][l*LW +: LW] = store[rdIdx];
      end
   end

   assign rdWord0 = rdArr[rdStart];
   assign rdWord1 = rdArr[~rdStart]; // R17
endmodule : dbsp_pair_array

// >>> logic/dbsp_pkg.sv
// Shared constants and types of the two-word burst DDR SRAM port
package dbsp_pkg;
   // 36-bit organisation
   localparam int DATA_W = 36;
   localparam int ADDR_W = 21;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   // 18-bit organisation, selected through the top-level parameters
   localparam int DATA_W_X18 = 18;
   localparam int ADDR_W_X18 = 22;
   localparam int LANES_X18 = 2;
   // Words per loaded address and number of internal arrays
   localparam int BURST_LEN = 2;
   localparam int ARRAYS = 2;
   // Fastest link rate for the bypassed-PLL single-cycle-latency mode
   localparam int LEGACY_MAX_MHZ = 167;
   // Width of the transaction counters in the system domain
   localparam int CNT_W = 16;
   // Event channels reported to the system domain
   localparam int EVT_N = 2;
   localparam int EVT_READ = 0;
   localparam int EVT_WRITE = 1;
   // Direction select encoding while the load strobe is low
   localparam logic RW_READ = 1'b1;
   // Reset values
   localparam logic SYNC_RST = 1'b0;
   localparam logic OE_N_IDLE = 1'b1;

   typedef enum logic [1:0] {
      DBSP_IDLE  = 2'b00,
      DBSP_READ  = 2'b01,
      DBSP_WRITE = 2'b10
   } dbsp_cmd_t;
endpackage : dbsp_pkg

// >>> logic/dbsp_sram_port.sv
// Double-data-rate two-word burst SRAM port, device end
// How it works
// R1 - Write words taken on both input clocks
// R2 - Read words driven on output clock edges
// R3 - Data pins float when no read
// R4 - Controller lowers load strobe with command
// R5 - Every access moves exactly two words
// R6 - Byte selects sampled with their word
// R7 - Deselected lane leaves stored byte alone
// R8 - Select n owns nine-bit lane n
// R9 - One address bus serves both directions
// R10 - Burst bit loads one-bit linear counter
// R11 - 21 or 22 address inputs
// R12 - Address ignored while port deselected
// R13 - Direction high reads, low writes
// R14 - Storage is two equal arrays
// R15 - Accesses start on true input clock
// R16 - Bypassed PLL gives single-cycle read latency
// R17 - Second word uses incremented burst bit
// R18 - Strobe high means deselected cycle
`timescale 1ns/1ps
module dbsp_sram_port #(
   parameter int DATA_W = dbsp_pkg::DATA_W,
   parameter int ADDR_W = dbsp_pkg::ADDR_W, // R11
   parameter int LANE_W = dbsp_pkg::LANE_W,
   parameter int LANES  = dbsp_pkg::LANES,
   parameter int CNT_W  = dbsp_pkg::CNT_W
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              en,
   input  wire logic              kClk,
   input  wire logic              cClk,
   input  wire logic              singleClockMode,
   input  wire logic              pllBypassN,
   input  wire logic              loadStrobeN,
   input  wire logic              rwSel,
   input  wire logic [ADDR_W-2:0] addr,
   input  wire logic              burstStartBit,
   input  wire logic [LANES-1:0]  byteLaneWriteSelN,
   input  wire logic [DATA_W-1:0] dqIn,
   output logic      [DATA_W-1:0] dqOut,
   output logic      [DATA_W-1:0] dqOeN,
   output logic                   legacyMode,
   output logic      [CNT_W-1:0]  readCount,
   output logic      [CNT_W-1:0]  writeCount
);

   // ---------------- Link domain (true input clock) ----------------
   logic linkRstMeta_r;
   logic linkRst_r;
   logic linkEnMeta_r;
   logic linkEn_r;

   always_ff @(posedge kClk) begin
      linkRstMeta_r <= rst;
      linkRst_r <= linkRstMeta_r;
      linkEnMeta_r <= en;
      linkEn_r <= linkEnMeta_r;
   end

   dbsp_pkg::dbsp_cmd_t cmdState_r;
   dbsp_pkg::dbsp_cmd_t cmdNxt;
   logic [ADDR_W-2:0]   cmdIdx_r;
   logic                cmdStart_r;
   logic [dbsp_pkg::EVT_N-1:0] evtTog_r;

   always_comb begin
      if (!loadStrobeN) begin // R4 R18
         cmdNxt = (rwSel == dbsp_pkg::RW_READ) ? dbsp_pkg::DBSP_READ
                                               : dbsp_pkg::DBSP_WRITE; // R13
      end else begin
         cmdNxt = dbsp_pkg::DBSP_IDLE;
      end
   end

   always_ff @(posedge kClk) begin // R15
      if (linkRst_r) begin
         cmdState_r <= dbsp_pkg::DBSP_IDLE;
      end else if (linkEn_r) begin
         cmdState_r <= cmdNxt;
      end
   end

   // One address bus for both directions, held while deselected
   always_ff @(posedge kClk) begin
      if (linkRst_r) begin
         cmdIdx_r <= '0;
         cmdStart_r <= 1'b0;
      end else if (linkEn_r && !loadStrobeN) begin // R9 R12
         cmdIdx_r <= addr;
         cmdStart_r <= burstStartBit; // R10
      end
   end

   always_ff @(posedge kClk) begin
      if (linkRst_r) begin
         evtTog_r <= '0;
      end else if (linkEn_r) begin
         unique case (cmdNxt)
            dbsp_pkg::DBSP_READ: begin
               evtTog_r[dbsp_pkg::EVT_READ] <= ~evtTog_r[dbsp_pkg::EVT_READ];
            end
            dbsp_pkg::DBSP_WRITE: begin
               evtTog_r[dbsp_pkg::EVT_WRITE] <= ~evtTog_r[dbsp_pkg::EVT_WRITE];
            end
            dbsp_pkg::DBSP_IDLE: begin
            end
         endcase
      end
   end

   // Write path: first word on the true clock one cycle after the command,
   // second on the complementary clock, both committed together
   logic [DATA_W-1:0] wrData0_r;
   logic [DATA_W-1:0] wrData1_r;
   logic [LANES-1:0]  wrSel0N_r;
   logic [LANES-1:0]  wrSel1N_r;
   logic [ADDR_W-2:0] wrIdx_r;
   logic              wrStart_r;
   logic              wrBeat_r;
   logic              commit_r;

   always_ff @(posedge kClk) begin
      if (linkRst_r) begin
         wrBeat_r <= 1'b0;
         commit_r <= 1'b0;
      end else if (linkEn_r) begin
         wrBeat_r <= (cmdState_r == dbsp_pkg::DBSP_WRITE);
         commit_r <= wrBeat_r; // R5
      end
   end

   always_ff @(posedge kClk) begin
      if (linkEn_r && cmdState_r == dbsp_pkg::DBSP_WRITE) begin
         wrData0_r <= dqIn; // R1
         wrSel0N_r <= byteLaneWriteSelN; // R6
         wrIdx_r <= cmdIdx_r;
         wrStart_r <= cmdStart_r;
      end
   end

   always_ff @(negedge kClk) begin
      if (linkEn_r && wrBeat_r) begin
         wrData1_r <= dqIn; // R1
         wrSel1N_r <= byteLaneWriteSelN; // R6
      end
   end

   // Read fetch on the complementary clock of the command cycle, so a
   // write committed on the same true edge is already visible
   logic [DATA_W-1:0] memWord0;
   logic [DATA_W-1:0] memWord1;
   logic [DATA_W-1:0] rdWord0_r;
   logic [DATA_W-1:0] rdWord1_r;
   logic              rdFetch_r;

   dbsp_pair_array #(
      .DW (DATA_W),
      .AW (ADDR_W),
      .LW (LANE_W),
      .NL (LANES)
   ) u_array (
      .clk     (kClk),
      .en      (linkEn_r),
      .wrEn    (commit_r),
      .wrIdx   (wrIdx_r),
      .wrStart (wrStart_r),
      .wrWord0 (wrData0_r),
      .wrWord1 (wrData1_r),
      .wrSel0N (wrSel0N_r),
      .wrSel1N (wrSel1N_r),
      .rdIdx   (cmdIdx_r),
      .rdStart (cmdStart_r),
      .rdWord0 (memWord0),
      .rdWord1 (memWord1)
   ); // R14

   always_ff @(negedge kClk) begin
      if (linkRst_r) begin
         rdFetch_r <= 1'b0;
      end else if (linkEn_r) begin
         rdFetch_r <= (cmdState_r == dbsp_pkg::DBSP_READ);
         rdWord0_r <= memWord0;
         rdWord1_r <= memWord1;
      end
   end

   // ---------------- Output domain ----------------
   // Without output clocks the input clocks time the read data. The pin is
   // a board strap; changing it live would glitch the output clock.
   logic outClk;
   assign outClk = singleClockMode ? kClk : cClk;

   logic outRstMeta_r;
   logic outRst_r;
   logic outEnMeta_r;
   logic outEn_r;
   logic bypMeta_r;
   logic byp_r;

   always_ff @(posedge outClk) begin
      outRstMeta_r <= rst;
      outRst_r <= outRstMeta_r;
      outEnMeta_r <= en;
      outEn_r <= outEnMeta_r;
      bypMeta_r <= ~pllBypassN;
      byp_r <= bypMeta_r;
   end

   // Output clocks run at the input clock rate with a fixed board skew;
   // the fetch registers hold a full cycle, which covers that skew
   logic [DATA_W-1:0] posQ_r;
   logic [DATA_W-1:0] negQ_r;
   logic [DATA_W-1:0] lateWord_r;
   logic              lateValid_r;
   logic              posOe_r;
   logic              negOe_r;

   always_ff @(posedge outClk) begin
      if (outRst_r) begin
         lateValid_r <= 1'b0;
         posOe_r <= 1'b0;
      end else if (outEn_r) begin
         lateValid_r <= rdFetch_r && !byp_r;
         lateWord_r <= rdWord1_r;
         if (rdFetch_r && byp_r) begin // R16
            posQ_r <= rdWord0_r;
            posOe_r <= 1'b1;
         end else if (lateValid_r) begin
            posQ_r <= lateWord_r; // R2
            posOe_r <= 1'b1;
         end else begin
            posOe_r <= 1'b0;
         end
      end
   end

   always_ff @(negedge outClk) begin
      if (outRst_r) begin
         negOe_r <= 1'b0;
      end else if (outEn_r) begin
         negOe_r <= rdFetch_r; // R2
         if (rdFetch_r) begin
            negQ_r <= byp_r ? rdWord1_r : rdWord0_r; // R16
         end
      end
   end

   // Double-rate output: high phase shows the true-edge word
   logic driveNow;
   assign driveNow = outClk ? posOe_r : negOe_r;
   assign dqOut = outClk ? posQ_r : negQ_r;
   assign dqOeN = {DATA_W{~driveNow}}; // R3

   // ---------------- System domain ----------------
   logic [dbsp_pkg::EVT_N-1:0] evtMeta_r;
   logic [dbsp_pkg::EVT_N-1:0] evtSync_r;
   logic [dbsp_pkg::EVT_N-1:0] evtLast_r;
   logic [dbsp_pkg::EVT_N-1:0][CNT_W-1:0] evtCnt_r;
   logic sysBypMeta_r;
   logic legacy_r;

   always_ff @(posedge clk) begin
      evtMeta_r <= evtTog_r;
      evtSync_r <= evtMeta_r;
      sysBypMeta_r <= ~pllBypassN;
   end

   for (genvar e = 0; e < dbsp_pkg::EVT_N; e++) begin : g_evt
      always_ff @(posedge clk) begin
         if (rst) begin
            evtLast_r[e] <= dbsp_pkg::SYNC_RST;
            evtCnt_r[e] <= '0;
         end else if (en) begin
            evtLast_r[e] <= evtSync_r[e];
            if (evtSync_r[e] != evtLast_r[e]) begin
               evtCnt_r[e] <= evtCnt_r[e] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         legacy_r <= 1'b0;
      end else if (en) begin
         legacy_r <= sysBypMeta_r;
      end
   end

   assign legacyMode = legacy_r;
   assign readCount = evtCnt_r[dbsp_pkg::EVT_READ];
   assign writeCount = evtCnt_r[dbsp_pkg::EVT_WRITE];

   // ---------------- Assertions ----------------
   sequence s_wr_cmd;
      !loadStrobeN && rwSel != dbsp_pkg::RW_READ && linkEn_r;
   endsequence

   sequence s_wr_beats;
      wrBeat_r ##1 commit_r;
   endsequence

   property p_rd_decode;
      @(posedge kClk) disable iff (linkRst_r)
      (!loadStrobeN && rwSel == dbsp_pkg::RW_READ && linkEn_r)
         |=> cmdState_r == dbsp_pkg::DBSP_READ;
   endproperty
   a_rd_decode: assert property (p_rd_decode) // R13
      else $error("read command not decoded as read");

   property p_wr_decode;
      @(posedge kClk) disable iff (linkRst_r)
      s_wr_cmd |=> cmdState_r == dbsp_pkg::DBSP_WRITE;
   endproperty
   a_wr_decode: assert property (p_wr_decode) // R13
      else $error("write command not decoded as write");

   property p_deselect;
      @(posedge kClk) disable iff (linkRst_r)
      loadStrobeN |=> cmdState_r == dbsp_pkg::DBSP_IDLE
                      && $stable(cmdIdx_r) && $stable(cmdStart_r);
   endproperty
   a_deselect: assert property (p_deselect) // R12
      else $error("address or command changed while deselected");

   property p_wr_burst;
      @(posedge kClk) disable iff (linkRst_r || !linkEn_r)
      s_wr_cmd |=> ##1 s_wr_beats;
   endproperty
   a_wr_burst: assert property (p_wr_burst) // R5
      else $error("write did not take two beats and commit");

   property p_wr_word0;
      @(posedge kClk) disable iff (linkRst_r || !linkEn_r)
      cmdState_r == dbsp_pkg::DBSP_WRITE
         |=> wrData0_r == $past(dqIn)
             && wrSel0N_r == $past(byteLaneWriteSelN);
   endproperty
   a_wr_word0: assert property (p_wr_word0) // R1
      else $error("first write word or selects not captured");

   property p_burst_bit;
      @(posedge kClk) disable iff (linkRst_r || !linkEn_r)
      s_wr_cmd ##1 1'b1 |=> wrStart_r == $past(burstStartBit, 2);
   endproperty
   a_burst_bit: assert property (p_burst_bit) // R10
      else $error("burst counter not loaded from burst bit");

   // Pins are sampled in the low phase, which only a read two edges back drives
   property p_float;
      @(posedge kClk) disable iff (linkRst_r || !linkEn_r || !singleClockMode)
      $past(cmdState_r) != dbsp_pkg::DBSP_READ |-> &dqOeN;
   endproperty
   a_float: assert property (p_float) // R3
      else $error("data pins driven with no read active");

   property p_legacy_lat;
      @(posedge kClk) disable iff (linkRst_r || !singleClockMode || !linkEn_r)
      (cmdNxt == dbsp_pkg::DBSP_READ && byp_r && outEn_r)
         |=> ##1 posOe_r && posQ_r == $past(memWord0, 1);
   endproperty
   a_legacy_lat: assert property (p_legacy_lat) // R16
      else $error("bypass mode read word not on next true edge");
endmodule : dbsp_sram_port

// >>> tb/dbsp_ctrl_model.sv
// Behavioural memory controller that drives the link side of the port
`timescale 1ns/1ps
module dbsp_ctrl_model (
   input  wire logic        kClk,
   output logic             loadStrobeN,
   output logic             rwSel,
   output logic [4:0]       addr,
   output logic             burstStartBit,
   output logic [3:0]       byteLaneWriteSelN,
   output logic [35:0]      dqIn,
   input  wire logic [35:0] dqOut,
   input  wire logic [35:0] dqOeN
);
   initial begin
      loadStrobeN = 1'b1;
      rwSel = 1'b1;
      addr = 5'h00;
      burstStartBit = 1'b0;
      byteLaneWriteSelN = 4'hf;
      dqIn = 36'h000000000;
   end

   // Deselected cycle; address and direction are scrambled so that a port
   // which fails to ignore them corrupts what is read later
   task automatic idle();
      loadStrobeN = 1'b1;
      addr = ~addr;
      rwSel = ~rwSel;
      burstStartBit = ~burstStartBit;
   endtask : idle

   task automatic doWrite(input logic [4:0] a, input logic b,
                          input logic [35:0] d0, input logic [35:0] d1,
                          input logic [3:0] s0, input logic [3:0] s1);
      @(posedge kClk);
      #1;
      loadStrobeN = 1'b0;
      rwSel = 1'b0;
      addr = a;
      burstStartBit = b;
      @(posedge kClk);
      #1;
      idle();
      dqIn = d0;
      byteLaneWriteSelN = s0;
      @(posedge kClk);
      #1;
      dqIn = d1;
      byteLaneWriteSelN = s1;
      @(posedge kClk);
      #1;
      dqIn = ~d1;
      byteLaneWriteSelN = ~s1;
   endtask : doWrite

   // Samples each read word mid-phase; oe reports drive, drive, released;
   // lg selects single-cycle latency, which moves every word half a cycle
   task automatic doRead(input logic [4:0] a, input logic b, input logic lg,
                         output logic [35:0] w0, output logic [35:0] w1,
                         output logic [2:0] oe);
      @(posedge kClk);
      #1;
      loadStrobeN = 1'b0;
      rwSel = 1'b1;
      addr = a;
      burstStartBit = b;
      @(posedge kClk);
      #1;
      idle();
      dqIn = ~dqIn;
      @(posedge kClk);
      if (!lg) begin
         @(kClk);
      end
      #7;
      w0 = dqOut;
      oe[0] = (dqOeN === 36'h000000000);
      @(kClk);
      #7;
      w1 = dqOut;
      oe[1] = (dqOeN === 36'h000000000);
      @(kClk);
      #7;
      oe[2] = (dqOeN === 36'hfffffffff);
   endtask : doRead
endmodule : dbsp_ctrl_model

// >>> tb/testbench.sv
// Self-checking bench of the burst SRAM port with a controller model
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [4:0]  a;
      logic        wb;
      logic [35:0] d0;
      logic [35:0] d1;
      logic [3:0]  s0;
      logic [3:0]  s1;
      logic        rb;
   } dbsp_tb_row_t;
   localparam int LW = dbsp_pkg::LANE_W;
   localparam int NROWS = 6;

   logic         clk;
   logic         kClk;
   logic         rst;
   logic         en;
   logic         singleClockMode;
   logic         pllBypassN;
   logic         loadStrobeN;
   logic         rwSel;
   logic [4:0]   addr;
   logic         burstStartBit;
   logic [3:0]   byteLaneWriteSelN;
   logic [35:0]  dqIn;
   logic [35:0]  dqOut;
   logic [35:0]  dqOeN;
   logic         legacyMode;
   logic [15:0]  readCount;
   logic [15:0]  writeCount;
   int           miscompares;
   int           checks;
   logic [35:0]  shadow [64];
   dbsp_tb_row_t rows [NROWS];
   logic [35:0]  w0;
   logic [35:0]  w1;
   logic [2:0]   oe;

   dbsp_sram_port #(.ADDR_W(6)) i_dut (
      .clk(clk), .rst(rst), .en(en), .kClk(kClk), .cClk(kClk),
      .singleClockMode(singleClockMode), .pllBypassN(pllBypassN),
      .loadStrobeN(loadStrobeN), .rwSel(rwSel), .addr(addr),
      .burstStartBit(burstStartBit),
      .byteLaneWriteSelN(byteLaneWriteSelN), .dqIn(dqIn),
      .dqOut(dqOut), .dqOeN(dqOeN), .legacyMode(legacyMode),
      .readCount(readCount), .writeCount(writeCount)
   );

   dbsp_ctrl_model i_ctrl (
      .kClk(kClk), .loadStrobeN(loadStrobeN), .rwSel(rwSel), .addr(addr),
      .burstStartBit(burstStartBit),
      .byteLaneWriteSelN(byteLaneWriteSelN), .dqIn(dqIn),
      .dqOut(dqOut), .dqOeN(dqOeN)
   );

   always #20 clk = ~clk;
   // Link clock runs free at a period unrelated to that of clk
   always #15 kClk = ~kClk;

   // Stored image after a lane-masked write
   function automatic logic [35:0] merge(input logic [35:0] old,
                                         input logic [35:0] d,
                                         input logic [3:0] s);
      logic [35:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (!s[i]) begin
            r[LW*i +: LW] = d[LW*i +: LW];
         end
      end
      return r;
   endfunction : merge

   task automatic check(input string what, input logic [35:0] expv,
                        input logic [35:0] got);
      checks++;
      if (got !== expv) begin
         $display("[ERR] %s expected %h seen %h", what, expv, got);
         miscompares++;
      end
   endtask : check

   task automatic test_done();
      if (miscompares == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   task automatic readBack(input logic [4:0] a, input logic rb);
      i_ctrl.doRead(a, rb, !pllBypassN, w0, w1, oe);
      check("read word0", shadow[{a, rb}], w0);
      check("read word1", shadow[{a, ~rb}], w1);
      check("read drive window", 36'h7, {33'h0, oe});
   endtask : readBack

   initial begin
      clk = 1'b0;
      kClk = 1'b0;
      rst = 1'b1;
      en = 1'b1;
      singleClockMode = 1'b1;
      pllBypassN = 1'b1;
      miscompares = 0;
      checks = 0;
      // First write to an address fills both words so no lane stays unknown
      rows = '{
         '{5'h03, 1'b0, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0, 1'b0},
         '{5'h03, 1'b1, 36'h0aaaaaaaa, 36'h155555555, 4'h5, 4'ha, 1'b0},
         '{5'h1f, 1'b1, 36'hfffffffff, 36'h000000000, 4'h0, 4'h0, 1'b1},
         '{5'h1f, 1'b0, 36'h000000000, 36'hfffffffff, 4'he, 4'h7, 1'b1},
         '{5'h00, 1'b0, 36'h111111111, 36'h222222222, 4'h0, 4'h0, 1'b1},
         '{5'h00, 1'b1, 36'h333333333, 36'h444444444, 4'hf, 4'hf, 1'b0}
      };
      repeat (20) @(posedge clk);
      #1;
      check("dqOeN in reset", 36'hfffffffff, dqOeN);
      check("writeCount in reset", 36'h0, {20'h0, writeCount});
      rst = 1'b0;
      repeat (12) @(posedge kClk);
      for (int i = 0; i < NROWS; i++) begin
         i_ctrl.doWrite(rows[i].a, rows[i].wb, rows[i].d0, rows[i].d1,
                        rows[i].s0, rows[i].s1);
         shadow[{rows[i].a, rows[i].wb}] =
            merge(shadow[{rows[i].a, rows[i].wb}], rows[i].d0, rows[i].s0);
         shadow[{rows[i].a, ~rows[i].wb}] =
            merge(shadow[{rows[i].a, ~rows[i].wb}], rows[i].d1, rows[i].s1);
         repeat (2) @(posedge kClk);
         readBack(rows[i].a, rows[i].rb);
      end
      // Long deselected stretch with a moving address must change nothing
      repeat (8) begin
         @(posedge kClk);
         #1;
         i_ctrl.idle();
      end
      readBack(5'h03, 1'b1);
      repeat (10) @(posedge clk);
      #1;
      check("writeCount", NROWS, {20'h0, writeCount});
      check("readCount", NROWS + 1, {20'h0, readCount});
      check("legacyMode", 36'h0, {35'h0, legacyMode});
      // Bypassed PLL: both read words come half a cycle earlier
      pllBypassN = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      check("legacyMode on", 36'h1, {35'h0, legacyMode});
      readBack(5'h1f, 1'b0);
      test_done();
   end

   // Whole run is under 20 us; ten times that means a hang
   initial begin
      #200000;
      miscompares++;
      test_done();
   end
endmodule : testbench
